// ==== dsl_pkg.sv ====
/*
  Shared types and constants for the converter select and load block.
  Assumes a single 250 MHz clock and host commands already decoded
  into strobes on the same clock.
*/
package dsl_pkg;

  localparam int unsigned DEV_ADDR_W = 6;
  localparam logic [5:0] DEV_ADDR_LO = 6'h28;
  localparam logic [5:0] DEV_ADDR_HI = 6'h2F;
  localparam int unsigned CONV_NUM_W = 3;
  localparam int unsigned NUM_CONV = 8;
  localparam int unsigned CONV_PER_MODULE = 2;
  localparam int unsigned NUM_SLAVE_MODULES = 3;
  localparam int unsigned HOST_WORD_W = 16;
  localparam int unsigned CONV_WIDTH = 12;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [7:0] SEL_NONE_RESET = 8'h00;
  localparam logic [2:0] CONV_NUM_RESET = 3'h0;
  localparam logic SEL_VALID_RESET = 1'b0;
  // Settling figure is host-side spacing, kept for reference only
  localparam int unsigned SETTLE_US = 20;
  localparam int unsigned CLOCK_MHZ = 250;
  localparam int unsigned SETTLE_CYCLES = SETTLE_US * CLOCK_MHZ;
  localparam int unsigned MIN_WRITE_SPACING = 4;

  typedef enum logic [1:0]
  {
    dsl_src_accum_a,
    dsl_src_accum_b,
    dsl_src_memory
  } dsl_src_t;

  typedef struct packed
  {
    logic valid;
    logic [DEV_ADDR_W-1:0] dev_addr;
    logic [CONV_NUM_W-1:0] conv_num;
  } dsl_select_t;

  typedef struct packed
  {
    logic output_from_accum_a;
    logic output_from_accum_b;
    logic output_from_memory;
    logic [DEV_ADDR_W-1:0] dev_addr;
    logic [HOST_WORD_W-1:0] data;
  } dsl_write_t;

  typedef struct packed
  {
    logic [CONV_NUM_W-1:0] conv_num;
    logic [HOST_WORD_W-1:0] data;
  } dsl_word_t;

endpackage : dsl_pkg

// ==== dsl_fifo.sv ====
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
module dsl_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 4
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } dsl_fifo_state_t;

  dsl_fifo_state_t state;
  dsl_fifo_state_t next_state;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  assign in_ready = (state.count != (AW + 1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data = state.mem[state.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_state = state;
    if (push)
    begin
      next_state.mem[state.wr] = in_data;
      next_state.wr = bump(state.wr);
    end
    if (pop)
    begin
      next_state.rd = bump(state.rd);
    end
    if (push && !pop)
    begin
      next_state.count = (AW + 1)'(state.count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_state.count = (AW + 1)'(state.count - 1'b1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else if (clock_en)
    begin
      state <= next_state;
    end
  end

endmodule : dsl_fifo

// ==== dsl_selector.sv ====
/*
  Per-address converter selection store, one entry per device address.
  Assumes select strobes are already qualified as addressed to this range.
*/
`timescale 1ns/1ps
module dsl_selector
  import dsl_pkg::*;
#(
  parameter int unsigned NUM_ADDR = 8
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic system_clear,
  input wire logic sel_strobe,
  input wire logic [2:0] sel_index,
  input wire logic [CONV_NUM_W-1:0] sel_conv,
  input wire logic [2:0] look_index,
  output dsl_pkg::dsl_select_t look_sel
);
  typedef struct packed
  {
    logic [NUM_ADDR-1:0] valid;
    logic [NUM_ADDR-1:0][CONV_NUM_W-1:0] conv;
  } dsl_sel_state_t;

  dsl_sel_state_t state;
  dsl_sel_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (system_clear)
    begin
      next_state = '0;
    end
    else if (sel_strobe)
    begin
      next_state.valid[sel_index] = 1'b1;
      next_state.conv[sel_index] = sel_conv;
    end
  end

  always_comb
  begin
    look_sel.valid = state.valid[look_index];
    look_sel.conv_num = state.conv[look_index];
    look_sel.dev_addr = DEV_ADDR_LO | DEV_ADDR_W'(look_index);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else if (clock_en)
    begin
      state <= next_state;
    end
  end

endmodule : dsl_selector

// ==== dsl_dac_select_load.sv ====
/*
  Master module front end: address decode, converter selection for the
  master and up to three slave modules, and loading of the selected
  converter buffer.
  Assumes host select and output strobes are one-cycle pulses on clock;
  system_clear is an asynchronous pin and is synchronised here.
*/
// Behaviour
// - respond only to device addresses 50-57 octal
// - select command latches converter number
// - converters 0,1 master; 2-7 three slaves
// - selection held across data writes
// - each address keeps own selection
// - data loads only selected converter buffer
// - right-adjusted two's complement, top bits ignored
// - 12-bit magnitude from eleven low bits
// - widths 10, 12, 14 supported
// - output equals code times scale step
// - accept writes every four host cycles
// - loaded word drives converter at once; here it reaches conv_code two cycles after the write, via the FIFO
// - system clear or power loss clears selection
// - master decodes for up to three slaves
`timescale 1ns/1ps
module dsl_dac_select_load
  import dsl_pkg::*;
#(
  parameter int unsigned CONV_W = CONV_WIDTH,
  parameter int unsigned SLAVES = NUM_SLAVE_MODULES,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic system_clear,
  input wire logic converter_select_cmd,
  input wire logic [DEV_ADDR_W-1:0] select_dev_addr,
  input wire logic [CONV_NUM_W-1:0] select_conv_num,
  input dsl_pkg::dsl_write_t host_write,
  output logic write_ready,
  output logic [NUM_CONV-1:0][CONV_W-1:0] conv_code,
  output logic [NUM_CONV-1:0] conv_load,
  output logic [NUM_CONV-1:0] conv_selected
);
  import dsl_pkg::*;

  localparam int unsigned WORD_W = CONV_NUM_W + HOST_WORD_W;

  typedef struct packed
  {
    logic [1:0] clr_sync;
    logic [NUM_CONV-1:0][CONV_W-1:0] code;
    logic [NUM_CONV-1:0] load;
  } dsl_top_state_t;

  dsl_top_state_t state;
  dsl_top_state_t next_state;

  logic clear_now;
  logic sel_hit;
  logic wr_any;
  logic wr_hit;
  dsl_select_t wr_sel;
  dsl_word_t fifo_in;
  dsl_word_t fifo_out;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_bits;
  logic [NUM_CONV-1:0] present;

  function automatic logic addr_in_range(input logic [DEV_ADDR_W-1:0] a);
    addr_in_range = (a >= DEV_ADDR_LO) && (a <= DEV_ADDR_HI);
  endfunction : addr_in_range

  function automatic int unsigned module_of(input logic [CONV_NUM_W-1:0] n);
    module_of = int'(n) / CONV_PER_MODULE;
  endfunction : module_of

  // keep low bits, sign at top of width
  // 12-bit code keeps sign plus eleven bits
  function automatic logic [CONV_W-1:0] trim_code(input logic [HOST_WORD_W-1:0] w);
    trim_code = w[CONV_W-1:0];
  endfunction : trim_code

  // converters present on master plus fitted slaves
  always_comb
  begin
    for (int i = 0; i < NUM_CONV; i++)
    begin
      present[i] = (module_of(CONV_NUM_W'(i)) <= SLAVES);
    end
  end

  assign clear_now = state.clr_sync[1];
  assign sel_hit = converter_select_cmd && addr_in_range(select_dev_addr);
  assign wr_any = host_write.output_from_accum_a || host_write.output_from_accum_b
    || host_write.output_from_memory;
  assign wr_hit = wr_any && addr_in_range(host_write.dev_addr);

  dsl_selector #(
    .NUM_ADDR(8)
  ) u_selector (
    .clock(clock),
    .reset_n(reset_n),
    .clock_en(clock_en),
    .system_clear(clear_now),
    .sel_strobe(sel_hit),
    .sel_index(select_dev_addr[2:0]),
    .sel_conv(select_conv_num),
    .look_index(host_write.dev_addr[2:0]),
    .look_sel(wr_sel)
  );

  // word tagged with the selected converter
  always_comb
  begin
    fifo_in.conv_num = wr_sel.conv_num;
    fifo_in.data = host_write.data;
    fifo_in_valid = wr_hit && wr_sel.valid && present[wr_sel.conv_num] && !clear_now;
  end

  dsl_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .clock_en(clock_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_bits)
  );

  assign fifo_out = fifo_out_bits;
  assign write_ready = fifo_in_ready;

  always_comb
  begin
    next_state = state;
    next_state.clr_sync = {state.clr_sync[0], system_clear};
    next_state.load = '0;
    if (fifo_out_valid)
    begin
      next_state.code[fifo_out.conv_num] = trim_code(fifo_out.data);
      next_state.load[fifo_out.conv_num] = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else if (clock_en)
    begin
      state <= next_state;
    end
  end

  // code is signed; analog stage scales by one step per count
  assign conv_code = state.code;
  assign conv_load = state.load;

  // foreign addresses alias into the table, so match in full
  always_comb
  begin
    conv_selected = '0;
    if (wr_sel.valid && (wr_sel.dev_addr == host_write.dev_addr))
    begin
      conv_selected[wr_sel.conv_num] = 1'b1;
    end
  end

endmodule : dsl_dac_select_load

// ==== dsl_dac_select_load_asserts.sv ====
/*
  Port-level checker for the converter select and load block.
  Assumes a bind to every instance and one clock domain.
*/
`timescale 1ns/1ps
module dsl_sl_chk
  import dsl_pkg::*;
#(
  parameter int unsigned CONV_W = CONV_WIDTH
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic system_clear,
  input wire logic converter_select_cmd,
  input wire logic [DEV_ADDR_W-1:0] select_dev_addr,
  input wire logic [CONV_NUM_W-1:0] select_conv_num,
  input wire dsl_pkg::dsl_write_t host_write,
  input wire logic write_ready,
  input wire logic [NUM_CONV-1:0][CONV_W-1:0] conv_code,
  input wire logic [NUM_CONV-1:0] conv_load,
  input wire logic [NUM_CONV-1:0] conv_selected
);
  logic wr_any;
  assign wr_any = host_write.output_from_accum_a | host_write.output_from_accum_b
    | host_write.output_from_memory;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  load_one_hot_a: assert property ($onehot0(conv_load)) else $error("two loads");
  sel_one_hot_a: assert property ($onehot0(conv_selected)) else $error("two selected");
  addr_range_a: assert property ((host_write.dev_addr < DEV_ADDR_LO ||
    host_write.dev_addr > DEV_ADDR_HI) |-> conv_selected == 8'h00) else $error("foreign addr");
  reset_clear_a: assert property (!$past(reset_n) |-> conv_load == 8'h00 &&
    conv_selected == 8'h00) else $error("state after reset");
  code_hold_a: assert property (conv_load == 8'h00 |-> $stable(conv_code))
    else $error("code moved");
  load_cause_a: assert property (conv_load != 8'h00 |-> $past(wr_any) ||
    $past(wr_any, 2)) else $error("load without write");
  ready_held_a: assert property (write_ready) else $error("write refused");
  clear_sel_a: assert property (system_clear [*4] |=> conv_selected == 8'h00)
    else $error("clear ignored");
  sel_latch_a: assert property (converter_select_cmd && clock_en &&
    select_dev_addr >= DEV_ADDR_LO && select_dev_addr <= DEV_ADDR_HI && !system_clear
    && !$past(system_clear) && !$past(system_clear, 2) && !$past(system_clear, 3)
    ##1 host_write.dev_addr == $past(select_dev_addr)
    |-> conv_selected == (8'h01 << $past(select_conv_num))) else $error("bad select");
  write_load_a: assert property (wr_any && clock_en && conv_selected != 8'h00
    && !system_clear && !$past(system_clear) && !$past(system_clear, 2)
    |-> ##[1:2] conv_load != 8'h00) else $error("write not loaded");
endmodule : dsl_sl_chk

bind dsl_dac_select_load dsl_sl_chk #(.CONV_W(CONV_W)) u_chk (.clock(clock),
  .reset_n(reset_n), .clock_en(clock_en), .system_clear(system_clear),
  .converter_select_cmd(converter_select_cmd), .select_dev_addr(select_dev_addr),
  .select_conv_num(select_conv_num), .host_write(host_write), .write_ready(write_ready),
  .conv_code(conv_code), .conv_load(conv_load), .conv_selected(conv_selected));

// ==== dsl_host_model.sv ====
/*
  Host bus model issuing select commands and programmed output writes.
  Assumes the caller sequences calls; each call starts after an edge.
*/
`timescale 1ns/1ps
module dsl_host_model
  import dsl_pkg::*;
(
  input wire logic clock,
  output logic select_cmd,
  output logic [DEV_ADDR_W-1:0] sel_addr,
  output logic [CONV_NUM_W-1:0] sel_num,
  output dsl_pkg::dsl_write_t host_write
);
  initial
  begin
    select_cmd = 1'b0;
    sel_addr = '0;
    sel_num = '0;
    host_write = '0;
  end
  task automatic sel(input logic [5:0] a, input logic [2:0] n);
    @(posedge clock); #1;
    select_cmd = 1'b1;
    sel_addr = a;
    sel_num = n;
    @(posedge clock); #1;
    select_cmd = 1'b0;
    sel_addr = ~a;
    sel_num = ~n;
  endtask : sel
  task automatic wr(input int s, input logic [5:0] a, input logic [15:0] d, input bit last);
    dsl_write_t w;
    // Built aside so the strobe never dips between back-to-back writes
    w = '0;
    w.dev_addr = a;
    w.data = d;
    w.output_from_accum_a = (s == 0);
    w.output_from_accum_b = (s == 1);
    w.output_from_memory = (s == 2);
    @(posedge clock); #1;
    host_write = w;
    if (last)
    begin
      @(posedge clock); #1;
      host_write = {3'b000, a, ~d};
    end
  endtask : wr
  task automatic look(input logic [5:0] a);
    @(posedge clock); #1;
    host_write.dev_addr = a;
  endtask : look
endmodule : dsl_host_model

// ==== tb_top.sv ====
/*
  Self-checking bench for the converter select and load block.
  Assumes the host model drives every bus input of the block.
*/
`timescale 1ns/1ps
module tb_top;
  import dsl_pkg::*;
  logic clock;
  logic reset_n;
  logic clock_en;
  logic system_clear;
  logic cmd;
  logic [5:0] sa;
  logic [2:0] sn;
  dsl_write_t hw;
  logic write_ready;
  logic [7:0][11:0] conv_code;
  logic [7:0] conv_load;
  logic [7:0] conv_selected;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int loads[8] = '{default: 0};
  dsl_host_model h (.clock(clock), .select_cmd(cmd), .sel_addr(sa), .sel_num(sn),
    .host_write(hw));
  dsl_dac_select_load DUT (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
    .system_clear(system_clear), .converter_select_cmd(cmd), .select_dev_addr(sa),
    .select_conv_num(sn), .host_write(hw), .write_ready(write_ready),
    .conv_code(conv_code), .conv_load(conv_load), .conv_selected(conv_selected));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Cut a hang short well past the expected run
  // Sampled mid-cycle so the one-cycle load pulse is never raced
  always @(negedge clock)
  begin
    cycles++;
    for (int i = 0; i < 8; i++) loads[i] += (conv_load[i] === 1'b1);
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  task automatic t_none;
    h.wr(0, 6'h2D, 16'h0123, 1);
    idle(3);
    chk("sel", 16'h0000, {8'h00, conv_selected});
    chk("loads", 16'h0000, 16'(loads.sum()));
    $display("t_none done");
  endtask : t_none
  task automatic t_map;
    logic [15:0] d;
    for (int k = 0; k < 8; k++)
    begin
      d = 16'h5000 + 16'(k) * 16'h0111;
      h.sel(6'h28, 3'(k));
      h.wr(k % 3, 6'h28, d, 1);
      idle(3);
      chk("code", {4'h0, d[11:0]}, {4'h0, conv_code[k]});
      chk("load", 16'h0001, 16'(loads[k]));
      chk("sel", 16'h0001 << k, {8'h00, conv_selected});
    end
    $display("t_map done");
  endtask : t_map
  task automatic t_persist;
    h.sel(6'h2B, 3'h5);
    h.sel(6'h2A, 3'h2);
    h.wr(0, 6'h2B, 16'h0ABC, 0);
    h.wr(1, 6'h2B, 16'h0123, 0);
    h.wr(2, 6'h2B, 16'h0FED, 1);
    idle(3);
    chk("code5", 16'h0FED, {4'h0, conv_code[5]});
    chk("load5", 16'h0004, 16'(loads[5]));
    chk("ready", 16'h0001, {15'h0000, write_ready});
    h.look(6'h2A);
    idle(1);
    chk("sel2A", 16'h0004, {8'h00, conv_selected});
    $display("t_persist done");
  endtask : t_persist
  task automatic t_trunc;
    h.sel(6'h2F, 3'h7);
    h.wr(0, 6'h2F, 16'h0800, 1);
    idle(3);
    chk("code2048", 16'h0800, {4'h0, conv_code[7]});
    h.wr(1, 6'h2F, 16'hF7FF, 1);
    idle(3);
    chk("codemax", 16'h07FF, {4'h0, conv_code[7]});
    $display("t_trunc done");
  endtask : t_trunc
  task automatic t_clear;
    h.sel(6'h2C, 3'h1);
    system_clear = 1'b1;
    idle(5);
    system_clear = 1'b0;
    idle(4);
    h.wr(0, 6'h2C, 16'h0111, 1);
    idle(3);
    chk("selclr", 16'h0000, {8'h00, conv_selected});
    chk("load1", 16'h0001, 16'(loads[1]));
    $display("t_clear done");
  endtask : t_clear
  task automatic t_range;
    h.sel(6'h2F, 3'h3);
    h.sel(6'h27, 3'h4);
    h.sel(6'h30, 3'h5);
    clock_en = 1'b0;
    h.sel(6'h29, 3'h6);
    clock_en = 1'b1;
    h.look(6'h29);
    idle(1);
    chk("selfrz", 16'h0000, {8'h00, conv_selected});
    h.look(6'h2F);
    idle(1);
    chk("sel2F", 16'h0008, {8'h00, conv_selected});
    h.look(6'h28);
    idle(1);
    chk("sel28", 16'h0000, {8'h00, conv_selected});
    // Out-of-range write aliases onto the entry for 0x2F
    h.wr(0, 6'h27, 16'h0555, 1);
    idle(3);
    chk("sel27", 16'h0000, {8'h00, conv_selected});
    chk("load3", 16'h0001, 16'(loads[3]));
    $display("t_range done");
  endtask : t_range
  initial
  begin
    reset_n = 1'b0;
    clock_en = 1'b1;
    system_clear = 1'b0;
    idle(8);
    reset_n = 1'b1;
    t_none();
    t_map();
    t_persist();
    t_trunc();
    t_clear();
    t_range();
    final_report();
  end
endmodule : tb_top
